// ===== pkg/ubc_pkg.sv
package ubc_pkg;
  // ------------------------------------------------------------
  // CRC constants
  // ------------------------------------------------------------
  localparam int          CRC_W          = 16;
  localparam logic [15:0] CRC_PRESET     = 16'h4ABA;
  localparam logic [15:0] CRC_POLY       = 16'h1021;
  localparam logic [15:0] CRC_RST        = 16'h0000;
  // Word count limit, 131072 bytes of 2-byte words
  localparam int          BURST_MAX_BYTES = 131072;
  localparam int          BURST_MAX_WORDS = BURST_MAX_BYTES / 2;
  localparam int          WCNT_W          = 18;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_DVH_PS      = 5000;
  localparam int HOLD_W        = 8;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } ubc_word_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_XFER,
    ST_TERM
  } ubc_state_type;

  // Sixteen data bits folded into the CRC in one step, MSB first
  function automatic logic [15:0] ubc_crc_next(input logic [15:0] crc, input logic [15:0] din);
    logic [15:0] c;
    logic        fb;
    c  = crc;
    fb = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      fb = c[15] ^ din[i];
      c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
endpackage

// ===== design/ubc_burst_crc.sv
`timescale 1ns/10ps
module ubc_burst_crc
  import ubc_pkg::*;
#(
  parameter int HOLD_PS = T_DVH_PS
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        strobe_pin,
  input  wire logic [15:0] dd_pin,
  input  wire logic        dev_is_sender,
  input  wire logic        burst_start,
  input  wire logic        xfer_phase,
  input  wire logic        burst_end,
  input  wire ubc_word_type tx_word,
  input  wire logic        crc_rx_strobe,
  output logic             word_strobe_q,
  output logic [15:0]      word_data_q,
  output logic [15:0]      crc_register_output_q,
  output logic             crc_check_done_q,
  output logic             crc_error_q,
  output logic             sender_paused_q,
  output logic             burst_long_q
);

  // ------------------------------------------------------------
  // Derived timing
  // ------------------------------------------------------------
  localparam int HOLD_RAW = (HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_CYC = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic        stb_s1_q, stb_s2_q, stb_s3_q;
  logic [15:0] dd_s1_q, dd_s2_q, dd_s3_q;

  // Three stages for strobe and data, kept aligned
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stb_s1_q <= 1'b0;
      stb_s2_q <= 1'b0;
      stb_s3_q <= 1'b0;
      dd_s1_q  <= 16'h0000;
      dd_s2_q  <= 16'h0000;
      dd_s3_q  <= 16'h0000;
    end else begin
      stb_s1_q <= strobe_pin;
      stb_s2_q <= stb_s1_q;
      stb_s3_q <= stb_s2_q;
      dd_s1_q  <= dd_pin;
      dd_s2_q  <= dd_s1_q;
      dd_s3_q  <= dd_s2_q;
    end
  end

  // ------------------------------------------------------------
  // Word strobe, CRC, compare and pause tracking
  // ------------------------------------------------------------
  ubc_state_type     state_q, state_d;
  logic              stb_level_q, stb_level_d;
  logic              stb_edge;
  logic              word_now;
  logic [15:0]       word_in;
  logic              word_strobe_d;
  logic [15:0]       word_data_d;
  logic [15:0]       crc_d;
  logic [15:0]       crc_register_next_value;
  logic              crc_check_done_d;
  logic              crc_error_d;
  logic [HOLD_W-1:0] hold_cnt_q, hold_cnt_d;
  logic              sender_paused_d;
  logic [WCNT_W-1:0] wcnt_q, wcnt_d;
  logic              burst_long_d;

  // Edge counts once stages two and three agree; no gap timer
  assign stb_edge = (stb_s2_q == stb_s3_q) && (stb_s3_q != stb_level_q);
  // Only edges inside the transfer phase carry words
  assign word_now = (state_q == ST_XFER) && xfer_phase &&
                    (dev_is_sender ? tx_word.valid : stb_edge);
  // Bit n of the word is data line n
  assign word_in  = dev_is_sender ? tx_word.data : dd_s3_q;
  // Whole word folded in one step
  assign crc_register_next_value = ubc_crc_next(crc_register_output_q, word_in);

  // Next-state logic
  always_comb begin
    state_d          = state_q;
    stb_level_d      = stb_level_q;
    word_strobe_d    = word_now;
    word_data_d      = word_now ? word_in : word_data_q;
    crc_d            = crc_register_output_q;
    crc_check_done_d = 1'b0;
    crc_error_d      = crc_error_q;
    hold_cnt_d       = hold_cnt_q;
    sender_paused_d  = sender_paused_q;
    wcnt_d           = wcnt_q;
    burst_long_d     = burst_long_q;
    if (stb_s2_q == stb_s3_q) begin
      stb_level_d = stb_s3_q;
    end
    if (burst_start) begin
      state_d         = ST_XFER;
      crc_d           = CRC_PRESET;
      crc_error_d     = 1'b0;
      wcnt_d          = '0;
      burst_long_d    = 1'b0;
      hold_cnt_d      = '0;
      sender_paused_d = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
        end
        ST_XFER: begin
          if (word_now) begin
            crc_d  = crc_register_next_value;
            wcnt_d = wcnt_q + WCNT_W'(1);
            if (wcnt_q >= WCNT_W'(BURST_MAX_WORDS)) begin
              burst_long_d = 1'b1;
            end
          end
          // Sender pause: hold time after last own word
          if (dev_is_sender && word_now) begin
            hold_cnt_d      = HOLD_LOAD;
            sender_paused_d = 1'b0;
          end else if (hold_cnt_q != '0) begin
            hold_cnt_d = hold_cnt_q - HOLD_W'(1);
            if (hold_cnt_q == HOLD_W'(1)) begin
              sender_paused_d = 1'b1;
            end
          end
          if (burst_end) begin
            state_d = ST_TERM;
          end
        end
        ST_TERM: begin
          // Host CRC is always delivered after termination
          if (crc_rx_strobe) begin
            crc_check_done_d = 1'b1;
            crc_error_d      = (dd_s3_q != crc_register_output_q);
            state_d          = ST_IDLE;
          end
        end
        // Unused state code falls back to idle
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q               <= ST_IDLE;
      stb_level_q           <= 1'b0;
      word_strobe_q         <= 1'b0;
      word_data_q           <= 16'h0000;
      crc_register_output_q <= CRC_RST;
      crc_check_done_q      <= 1'b0;
      crc_error_q           <= 1'b0;
      hold_cnt_q            <= '0;
      sender_paused_q       <= 1'b0;
      wcnt_q                <= '0;
      burst_long_q          <= 1'b0;
    end else begin
      state_q               <= state_d;
      stb_level_q           <= stb_level_d;
      word_strobe_q         <= word_strobe_d;
      word_data_q           <= word_data_d;
      crc_register_output_q <= crc_d;
      crc_check_done_q      <= crc_check_done_d;
      crc_error_q           <= crc_error_d;
      hold_cnt_q            <= hold_cnt_d;
      sender_paused_q       <= sender_paused_d;
      wcnt_q                <= wcnt_d;
      burst_long_q          <= burst_long_d;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_preset;
    @(posedge clk) disable iff (!rst_n)
      burst_start |=> crc_register_output_q == CRC_PRESET;
  endproperty
  a_preset: assert property (p_preset) else $error("CRC not preset at burst start");

  property p_fifo_crc_same;
    @(posedge clk) disable iff (!rst_n)
      word_strobe_q && !$past(burst_start) |->
        crc_register_output_q == ubc_crc_next($past(crc_register_output_q), word_data_q);
  endproperty
  a_fifo_crc_same: assert property (p_fifo_crc_same) else $error("CRC and buffer word disagree");

  property p_no_word_no_step;
    @(posedge clk) disable iff (!rst_n)
      !word_now && !burst_start |=> $stable(crc_register_output_q);
  endproperty
  a_no_word_no_step: assert property (p_no_word_no_step) else $error("CRC moved without a word");

  property p_outside_xfer;
    @(posedge clk) disable iff (!rst_n)
      (!xfer_phase || state_q != ST_XFER) |=> !word_strobe_q;
  endproperty
  a_outside_xfer: assert property (p_outside_xfer) else $error("Word taken outside transfer phase");

  property p_slow_edge;
    @(posedge clk) disable iff (!rst_n)
      state_q == ST_XFER && xfer_phase && !dev_is_sender && !burst_start && stb_edge
        |=> word_strobe_q && crc_register_output_q == ubc_crc_next($past(crc_register_output_q), $past(dd_s3_q));
  endproperty
  a_slow_edge: assert property (p_slow_edge) else $error("Qualified strobe edge dropped");

  property p_compare;
    @(posedge clk) disable iff (!rst_n)
      state_q == ST_TERM && crc_rx_strobe && !burst_start
        |=> crc_check_done_q && crc_error_q == ($past(dd_s3_q) != $past(crc_register_output_q));
  endproperty
  a_compare: assert property (p_compare) else $error("CRC compare result wrong");

  property p_pause;
    @(posedge clk) disable iff (!rst_n)
      state_q == ST_XFER && hold_cnt_q == HOLD_W'(1) && !word_now && !burst_start |=> sender_paused_q;
  endproperty
  a_pause: assert property (p_pause) else $error("Sender pause not reached after hold");

  property p_pause_clear;
    @(posedge clk) disable iff (!rst_n)
      dev_is_sender && word_now && !burst_start |=> !sender_paused_q ##0 hold_cnt_q == HOLD_LOAD;
  endproperty
  a_pause_clear: assert property (p_pause_clear) else $error("Pause not cleared by word");

  property p_long;
    @(posedge clk) disable iff (!rst_n)
      word_now && !burst_start && wcnt_q >= WCNT_W'(BURST_MAX_WORDS) |=> burst_long_q;
  endproperty
  a_long: assert property (p_long) else $error("Long burst not flagged");

endmodule

// ===== verif/ubc_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host adapter side of the link
// ----------------------------------------
module ubc_host_model (
  input  wire logic        clk,
  output logic             strobe_pin,
  output logic [15:0]      dd_pin
);
  // Strobe idles low
  initial begin
    strobe_pin = 1'b0;
    dd_pin     = 16'h0000;
  end
  // One word per strobe edge, four clocks per edge
  task automatic send_word(input logic [15:0] w);
    @(posedge clk) dd_pin <= w;
    @(posedge clk) strobe_pin <= ~strobe_pin;
    @(posedge clk);
    @(posedge clk) dd_pin <= ~w;
  endtask
  // Strobe raised again after termination, no data on it
  task automatic reassert(input logic [15:0] junk);
    @(posedge clk) dd_pin <= junk;
    strobe_pin <= 1'b1;
  endtask
  // Own CRC on the data lines after every burst
  task automatic send_crc(input logic [15:0] c);
    @(posedge clk) dd_pin <= c;
  endtask
endmodule

// ===== verif/udma_burst_crc_and_strobe_tb.sv
`timescale 1ns/10ps
module udma_burst_crc_and_strobe_tb import ubc_pkg::*; ;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         strobe_pin;
  logic [15:0]  dd_pin;
  logic         dev_is_sender = 1'b0;
  logic         burst_start = 1'b0;
  logic         xfer_phase = 1'b0;
  logic         burst_end = 1'b0;
  ubc_word_type tx_word = '0;
  logic         crc_rx_strobe = 1'b0;
  logic         word_strobe_q;
  logic [15:0]  word_data_q;
  logic [15:0]  crc_q;
  logic         done_q;
  logic         err_q;
  logic         paused_q;
  logic         long_q;
  int           bad_count = 0;
  int           total_checks = 0;
  int           wcount = 0;

  always #4 clk = ~clk;

  ubc_host_model host (.clk(clk), .strobe_pin(strobe_pin), .dd_pin(dd_pin));

  ubc_burst_crc dut (
    .clk(clk), .rst_n(rst_n), .strobe_pin(strobe_pin), .dd_pin(dd_pin),
    .dev_is_sender(dev_is_sender), .burst_start(burst_start), .xfer_phase(xfer_phase),
    .burst_end(burst_end), .tx_word(tx_word), .crc_rx_strobe(crc_rx_strobe),
    .word_strobe_q(word_strobe_q), .word_data_q(word_data_q), .crc_register_output_q(crc_q),
    .crc_check_done_q(done_q), .crc_error_q(err_q), .sender_paused_q(paused_q), .burst_long_q(long_q)
  );

  // Counts buffer writes
  always @(posedge clk) begin
    if (burst_start === 1'b1) wcount <= 0;
    else if (word_strobe_q === 1'b1) wcount <= wcount + 1;
  end

  function automatic logic [15:0] ref_crc(logic [15:0] c, logic [15:0] d);
    for (int i = 15; i >= 0; i--) c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
    return c;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic start_burst();
    @(posedge clk) burst_start <= 1'b1;
    xfer_phase <= 1'b1;
    @(posedge clk) burst_start <= 1'b0;
    #1 check(crc_q, 16'h4ABA);
    check(16'(err_q), 16'h0000);
  endtask

  task automatic finish_burst(input logic [15:0] c, input logic e, input int n);
    @(posedge clk) burst_end <= 1'b1;
    xfer_phase <= 1'b0;
    @(posedge clk) burst_end <= 1'b0;
    host.reassert(~c);
    host.send_crc(c);
    repeat (5) @(posedge clk);
    crc_rx_strobe <= 1'b1;
    @(posedge clk) crc_rx_strobe <= 1'b0;
    #1 check(16'(done_q), 16'h0001);
    check(16'(err_q), 16'(e));
    check(16'(wcount), 16'(n));
  endtask

  task automatic test_host_burst();
    logic [15:0] w [4];
    logic [15:0] exp;
    w = '{16'h1234, 16'hABCD, 16'h0000, 16'hFFFF};
    exp = 16'h4ABA;
    start_burst();
    for (int i = 0; i < 4; i++) begin
      if (i == 2) repeat (300) @(posedge clk);
      host.send_word(w[i]);
      exp = ref_crc(exp, w[i]);
    end
    repeat (3) @(posedge clk);
    #1 check(crc_q, exp);
    check(word_data_q, 16'hFFFF);
    finish_burst(exp, 1'b0, 4);
    $display("test host burst done");
  endtask

  task automatic test_bad_crc();
    logic [15:0] exp;
    start_burst();
    host.send_word(16'h5A5A);
    exp = ref_crc(16'h4ABA, 16'h5A5A);
    repeat (3) @(posedge clk);
    #1 check(crc_q, exp);
    finish_burst(exp ^ 16'h0001, 1'b1, 1);
    $display("test bad crc done");
  endtask

  task automatic test_dev_send();
    logic [15:0] exp;
    exp = 16'h4ABA;
    dev_is_sender <= 1'b1;
    start_burst();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) tx_word <= '{valid: 1'b1, data: 16'h0F01 + 16'(i)};
      exp = ref_crc(exp, 16'h0F01 + 16'(i));
    end
    @(posedge clk) tx_word <= '{valid: 1'b0, data: 16'hC3C3};
    #1 check(16'(paused_q), 16'h0000);
    @(posedge clk);
    #1 check(16'(paused_q), 16'h0001);
    check(crc_q, exp);
    finish_burst(exp, 1'b0, 3);
    dev_is_sender <= 1'b0;
    $display("test device send done");
  endtask

  // One word per clock past the long-burst limit
  task automatic test_long_burst();
    logic [15:0] exp;
    exp = 16'h4ABA;
    for (int i = 0; i <= BURST_MAX_WORDS; i++) exp = ref_crc(exp, 16'h00FF);
    @(posedge clk) dev_is_sender <= 1'b1;
    start_burst();
    @(posedge clk) tx_word <= '{valid: 1'b1, data: 16'h00FF};
    repeat (BURST_MAX_WORDS) @(posedge clk);
    #1 check(16'(long_q), 16'h0000);
    check(16'(paused_q), 16'h0000);
    @(posedge clk) tx_word <= '{valid: 1'b0, data: 16'h00FF};
    #1 check(16'(long_q), 16'h0001);
    check(crc_q, exp);
    finish_burst(exp, 1'b0, 65537);
    dev_is_sender <= 1'b0;
    $display("test long burst done");
  endtask

  // Watchdog against a hang
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    test_host_burst();
    test_bad_crc();
    test_dev_send();
    test_long_burst();
    print_verdict();
  end
endmodule
